// File: led_slot_pkg.sv
// constants, register map and carrier types for the led slot timing block
// assumes a 32-bit ahb-lite slave port and a 125 MHz ref_clk
package led_slot_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_SLOT_A_TRAIN = 8'h31;
    localparam logic [7:0] IDX_SUPPRESS = 8'h34;
    localparam logic [7:0] IDX_SLOT_B_SHAPE = 8'h35;
    localparam logic [7:0] IDX_SLOT_B_TRAIN = 8'h36;
    localparam logic [7:0] IDX_SHUTDOWN_EXT = 8'h37;
    localparam logic [7:0] IDX_GLOBAL_CFG = 8'h3C;
    localparam logic [7:0] IDX_SLOT_CTRL = 8'h3D;
    localparam logic [7:0] IDX_SLOT_STATUS = 8'h3E;
    localparam logic [7:0] IDX_SLOT_A_SHAPE = 8'h3F;
    localparam logic [7:0] IDX_BIAS_OVR = 8'h40;

    // reset values
    localparam logic [15:0] RST_TRAIN = 16'h0818;
    localparam logic [15:0] RST_SHAPE = 16'h0320;
    localparam logic [15:0] RST_SUPPRESS = 16'h0000;
    localparam logic [15:0] RST_SHUTDOWN_EXT = 16'h0000;
    localparam logic [15:0] RST_GLOBAL_CFG = 16'h3006;
    localparam logic [15:0] RST_BIAS_OVR = 16'h0020;

    // field positions
    localparam int COUNT_LSB = 8;
    localparam int SPACING_LSB = 0;
    localparam int WIDTH_LSB = 8;
    localparam int DELAY_LSB = 0;
    localparam int LIGHT_OFF_A_BIT = 8;
    localparam int LIGHT_OFF_B_BIT = 9;
    localparam int EXT_A_LSB = 0;
    localparam int EXT_B_LSB = 8;
    localparam int SECOND_CH_LSB = 10;
    localparam int UPPER_CH_LSB = 13;
    localparam int FRONTEND_LSB = 3;
    localparam int CATHODE_BIT = 9;
    localparam int OVR_EN_BIT = 7;
    localparam int OVR_A_LSB = 8;
    localparam int OVR_B_LSB = 10;
    localparam int OVR_SLEEP_LSB = 12;

    // timing: one microsecond step at ref_clk rate
    localparam int CLK_MHZ = 125;
    localparam int STEP_NS = 1000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int STEP_CYCLES = STEP_NS / CLK_PERIOD_NS;

    // slot selector
    typedef enum logic [1:0] {
        SLOT_IDLE = 2'b00,
        SLOT_A = 2'b01,
        SLOT_B = 2'b10
    } slot_sel_t;

    // pulse train settings handed to the sequencer
    typedef struct packed {
        logic [7:0] count;
        logic [9:0] spacing;
        logic [4:0] length;
        logic [7:0] delay;
        logic light_off;
    } train_cfg_t;

    // analogue power-down and bias controls
    typedef struct packed {
        logic [2:0] ch1_off;
        logic [2:0] ch2_off;
        logic [2:0] ch34_off;
        logic [1:0] cathode_a;
        logic [1:0] cathode_b;
        logic [1:0] cathode_sleep;
        logic cathode_high;
        logic override;
    } afe_ctrl_t;
endpackage : led_slot_pkg

// File: led_slot_timing_config.sv
// register bank and slot timing for the two led time slots
// assumes an ahb-lite master on ref_clk, single word transfers only
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// (RULE_01) slot A emits count pulses from bits 15:8, reset 8.
// (RULE_02) slot A pulses spaced by bits 7:0 microseconds, reset 0x18.
// (RULE_03) bit 9 suppresses slot B led current, driver stays on.
// (RULE_04) bit 8 suppresses slot A led current, slot keeps running.
// (RULE_05) suppressed slots still sample; only pulsed current stops.
// (RULE_06) software uses slot enable, not suppress bits, to stop slots.
// (RULE_07) software may suppress both leds for dark readings.
// (RULE_08) slot B pulse width from bits 12:8 microseconds, reset 3.
// (RULE_09) slot B first pulse delayed by bits 7:0, reset 0x20.
// (RULE_10) slot B emits count pulses from bits 15:8, reset 8.
// (RULE_11) slot B pulses spaced by bits 7:0 microseconds, reset 0x18.
// (RULE_12) bits 9:8 of extension register are slot B spacing msbs.
// (RULE_13) bits 1:0 of extension register are slot A spacing msbs.
// (RULE_14) bits 15:13 power down shared channel 3/4 amplifiers.
// (RULE_15) bits 12:10 power down channel 2 amplifiers.
// (RULE_16) bits 8:3 power down channel 1 and channels 2-4 amplifiers.
// (RULE_17) bit 9 selects cathode bias 1.3 V or 1.8 V.
// (RULE_18) override enable replaces cathode bit with per-slot settings.
// (RULE_19) software writes reserved fields with fixed values only.
// (RULE_20) pulse k starts at offset plus k times period, lasts width.
module led_slot_timing_config
    import led_slot_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic slot_a_start,
    input wire logic slot_b_start,
    input wire logic sleep_mode,
    output logic led_a_pulse,
    output logic led_b_pulse,
    output logic driver_a_on,
    output logic driver_b_on,
    output led_slot_pkg::afe_ctrl_t afe_ctrl,
    output logic [1:0] cathode_sel,
    output led_slot_pkg::slot_sel_t active_slot
);
    import led_slot_pkg::*;

    // register storage
    logic [15:0] a_train_reg;
    logic [15:0] suppress_reg;
    logic [15:0] b_shape_reg;
    logic [15:0] b_train_reg;
    logic [15:0] ext_reg;
    logic [15:0] global_reg;
    logic [15:0] a_shape_reg;
    logic [15:0] bias_reg;
    logic [1:0] ctrl_reg;

    // ahb data phase capture
    logic wr_pend_reg;
    logic [7:0] wr_idx_reg;
    logic [31:0] rdata_reg;

    // synchronised slot triggers and sleep
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;

    // microsecond tick divider
    logic [6:0] div_reg;
    logic us_tick;

    wire access_ok;
    wire [7:0] addr_idx;
    wire addr_aligned;
    logic [31:0] rd_mux;
    wire a_busy;
    wire b_busy;
    wire a_go;
    wire b_go;
    train_cfg_t a_cfg;
    train_cfg_t b_cfg;

    // address decode: word index from byte address
    assign access_ok = hsel && hready && htrans[1];
    assign addr_idx = haddr[9:2];
    assign addr_aligned = (haddr[1:0] == 2'h0) && (haddr[31:10] == 22'h000000);

    // read mux; unmapped reads return zero
    always_comb begin
        rd_mux = 32'h00000000;
        if (addr_aligned) begin
            unique case (addr_idx)
                IDX_SLOT_A_TRAIN: rd_mux = {16'h0000, a_train_reg};
                IDX_SUPPRESS: rd_mux = {16'h0000, suppress_reg};
                IDX_SLOT_B_SHAPE: rd_mux = {16'h0000, b_shape_reg};
                IDX_SLOT_B_TRAIN: rd_mux = {16'h0000, b_train_reg};
                IDX_SHUTDOWN_EXT: rd_mux = {16'h0000, ext_reg};
                IDX_GLOBAL_CFG: rd_mux = {16'h0000, global_reg};
                IDX_SLOT_CTRL: rd_mux = {30'h00000000, ctrl_reg};
                IDX_SLOT_STATUS: rd_mux = {30'h00000000, b_busy, a_busy};
                IDX_SLOT_A_SHAPE: rd_mux = {16'h0000, a_shape_reg};
                IDX_BIAS_OVR: rd_mux = {16'h0000, bias_reg};
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    // address phase: latch write target, read data ready for data phase
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 8'h00;
            rdata_reg <= 32'h00000000;
        end else begin
            wr_pend_reg <= access_ok && hwrite && addr_aligned;
            wr_idx_reg <= addr_idx;
            if (access_ok && !hwrite) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // data phase writes; unmapped writes are dropped
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_train_reg <= RST_TRAIN;
            suppress_reg <= RST_SUPPRESS;
            b_shape_reg <= RST_SHAPE;
            b_train_reg <= RST_TRAIN;
            ext_reg <= RST_SHUTDOWN_EXT;
            global_reg <= RST_GLOBAL_CFG;
            a_shape_reg <= RST_SHAPE;
            bias_reg <= RST_BIAS_OVR;
            ctrl_reg <= 2'h3;
        end else if (wr_pend_reg) begin
            unique case (wr_idx_reg)
                IDX_SLOT_A_TRAIN: a_train_reg <= hwdata[15:0];
                IDX_SUPPRESS: suppress_reg <= hwdata[15:0];
                IDX_SLOT_B_SHAPE: b_shape_reg <= hwdata[15:0];
                IDX_SLOT_B_TRAIN: b_train_reg <= hwdata[15:0];
                IDX_SHUTDOWN_EXT: ext_reg <= hwdata[15:0];
                IDX_GLOBAL_CFG: global_reg <= hwdata[15:0];
                IDX_SLOT_CTRL: ctrl_reg <= hwdata[1:0];
                IDX_SLOT_A_SHAPE: a_shape_reg <= hwdata[15:0];
                IDX_BIAS_OVR: bias_reg <= hwdata[15:0];
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;

    // two-stage synchronisers for external triggers and sleep
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else begin
            sync1_reg <= {sleep_mode, slot_b_start, slot_a_start};
            sync2_reg <= sync1_reg;
        end
    end

    // one microsecond enable from ref_clk
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 7'h00;
        end else if (div_reg == 7'(STEP_CYCLES - 1)) begin
            div_reg <= 7'h00;
        end else begin
            div_reg <= div_reg + 7'h01;
        end
    end
    assign us_tick = (div_reg == 7'(STEP_CYCLES - 1));

    // slot A train settings
    assign a_cfg.count = a_train_reg[COUNT_LSB +: 8]; // RULE_01
    assign a_cfg.spacing = {ext_reg[EXT_A_LSB +: 2], a_train_reg[SPACING_LSB +: 8]}; // RULE_02 RULE_13
    assign a_cfg.length = a_shape_reg[WIDTH_LSB +: 5];
    assign a_cfg.delay = a_shape_reg[DELAY_LSB +: 8];
    assign a_cfg.light_off = suppress_reg[LIGHT_OFF_A_BIT]; // RULE_04

    // slot B train settings
    assign b_cfg.count = b_train_reg[COUNT_LSB +: 8]; // RULE_10
    assign b_cfg.spacing = {ext_reg[EXT_B_LSB +: 2], b_train_reg[SPACING_LSB +: 8]}; // RULE_11 RULE_12
    assign b_cfg.length = b_shape_reg[WIDTH_LSB +: 5]; // RULE_08
    assign b_cfg.delay = b_shape_reg[DELAY_LSB +: 8]; // RULE_09
    assign b_cfg.light_off = suppress_reg[LIGHT_OFF_B_BIT]; // RULE_03

    // slot enables gate the start triggers; slot B waits for slot A
    assign a_go = ctrl_reg[0] && sync2_reg[0] && !b_busy;
    assign b_go = ctrl_reg[1] && sync2_reg[1] && !a_busy && !a_go; // same-cycle requests go to slot A

    // slot A sequencer
    pulse_train_seq u_slot_a (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .us_tick(us_tick),
        .start(a_go),
        .cfg(a_cfg),
        .led_pulse(led_a_pulse),
        .busy(a_busy)
    );

    // slot B sequencer
    pulse_train_seq u_slot_b (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .us_tick(us_tick),
        .start(b_go),
        .cfg(b_cfg),
        .led_pulse(led_b_pulse),
        .busy(b_busy)
    );

    // drivers stay powered while their slot runs, even when suppressed
    assign driver_a_on = a_busy; // RULE_04 RULE_05
    assign driver_b_on = b_busy; // RULE_03 RULE_05
    assign active_slot = a_busy ? SLOT_A : (b_busy ? SLOT_B : SLOT_IDLE);

    // analogue power-down controls
    assign afe_ctrl.ch1_off = global_reg[FRONTEND_LSB +: 3]; // RULE_16
    assign afe_ctrl.ch2_off = ext_reg[SECOND_CH_LSB +: 3] | global_reg[FRONTEND_LSB + 3 +: 3]; // RULE_15 RULE_16
    assign afe_ctrl.ch34_off = ext_reg[UPPER_CH_LSB +: 3] | global_reg[FRONTEND_LSB + 3 +: 3]; // RULE_14 RULE_16
    assign afe_ctrl.cathode_a = bias_reg[OVR_A_LSB +: 2];
    assign afe_ctrl.cathode_b = bias_reg[OVR_B_LSB +: 2];
    assign afe_ctrl.cathode_sleep = bias_reg[OVR_SLEEP_LSB +: 2];
    assign afe_ctrl.cathode_high = global_reg[CATHODE_BIT]; // RULE_17
    assign afe_ctrl.override = bias_reg[OVR_EN_BIT]; // RULE_18

    // effective cathode code: 2'b00 high bias, 2'b01 equal to anode
    always_comb begin
        cathode_sel = global_reg[CATHODE_BIT] ? 2'h0 : 2'h1; // RULE_17
        if (bias_reg[OVR_EN_BIT]) begin
            if (sync2_reg[2]) begin
                cathode_sel = bias_reg[OVR_SLEEP_LSB +: 2]; // RULE_18
            end else if (b_busy) begin
                cathode_sel = bias_reg[OVR_B_LSB +: 2]; // RULE_18
            end else begin
                cathode_sel = bias_reg[OVR_A_LSB +: 2]; // RULE_18
            end
        end
    end
endmodule : led_slot_timing_config

// File: led_slot_timing_config_sva.sv
// assertion checker for the led slot timing register block
// assumes it is bound onto the block's top-level ports
`timescale 1ns/100ps
module led_slot_timing_config_sva
    import led_slot_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic slot_a_start,
    input wire logic slot_b_start,
    input wire logic sleep_mode,
    input wire logic led_a_pulse,
    input wire logic led_b_pulse,
    input wire logic driver_a_on,
    input wire logic driver_b_on,
    input wire led_slot_pkg::afe_ctrl_t afe_ctrl,
    input wire logic [1:0] cathode_sel,
    input wire led_slot_pkg::slot_sel_t active_slot
);
    import led_slot_pkg::*;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // bus answers at once and never errors
    a_ready_high: assert property (hreadyout)
        else $error("hreadyout dropped");
    a_resp_okay: assert property (!hresp)
        else $error("error response seen");
    a_rdata_upper: assert property (hrdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    // slot trains never overlap
    a_slots_exclusive: assert property (!(driver_a_on && driver_b_on))
        else $error("both slots running");
    // led current only while its slot runs
    a_led_a_driven: assert property (led_a_pulse |-> driver_a_on)
        else $error("slot a led without driver");
    a_led_b_driven: assert property (led_b_pulse |-> driver_b_on)
        else $error("slot b led without driver");
    // without override, cathode bias follows the single bias bit
    a_cathode_plain: assert property (!afe_ctrl.override |-> cathode_sel == {1'b0, !afe_ctrl.cathode_high})
        else $error("cathode select mismatch");
    // a slot B pulse lasts at least eight ref_clk cycles
    a_width_min: assert property ($rose(led_b_pulse) |-> led_b_pulse [*8])
        else $error("slot b pulse too short");
    // slot A train starts only after a synchronised start request
    a_start_sync: assert property ($rose(driver_a_on) |-> $past(slot_a_start, 2) || $past(slot_a_start, 3))
        else $error("slot a started without request");
endmodule : led_slot_timing_config_sva
bind led_slot_timing_config led_slot_timing_config_sva u_sva (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .slot_a_start(slot_a_start),
    .slot_b_start(slot_b_start), .sleep_mode(sleep_mode), .led_a_pulse(led_a_pulse), .led_b_pulse(led_b_pulse),
    .driver_a_on(driver_a_on), .driver_b_on(driver_b_on), .afe_ctrl(afe_ctrl), .cathode_sel(cathode_sel),
    .active_slot(active_slot));

// File: pulse_train_seq.sv
// one slot's led pulse train sequencer
// assumes a one-cycle microsecond tick from the parent
`timescale 1ns/100ps
module pulse_train_seq
    import led_slot_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic us_tick,
    input wire logic start,
    input wire led_slot_pkg::train_cfg_t cfg,
    output logic led_pulse,
    output logic busy
);
    import led_slot_pkg::*;

    logic [17:0] us_reg;
    logic [17:0] us_next;
    logic [7:0] idx_reg;
    logic [7:0] idx_next;
    logic running_reg;
    logic pulse_reg;
    logic [17:0] start_us;
    logic [17:0] end_us;
    wire last_done;
    wire in_pulse;

    // pulse k starts at delay + k*spacing and lasts length microseconds
    assign start_us = 18'(cfg.delay) + 18'(idx_reg) * 18'(cfg.spacing); // RULE_20 RULE_09
    assign end_us = start_us + 18'(cfg.length); // RULE_08
    assign in_pulse = running_reg && (us_reg >= start_us) && (us_reg < end_us) && (cfg.length != 5'h00);
    assign last_done = (us_reg >= end_us) && ((idx_reg + 8'h01) >= cfg.count); // RULE_01 RULE_10
    assign us_next = us_reg + 18'h00001;
    assign idx_next = (us_reg >= end_us) ? idx_reg + 8'h01 : idx_reg; // RULE_02 RULE_11

    // microsecond timeline and pulse index
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            us_reg <= 18'h00000;
            idx_reg <= 8'h00;
            running_reg <= 1'b0;
        end else if (start && !running_reg) begin
            us_reg <= 18'h00000;
            idx_reg <= 8'h00;
            running_reg <= (cfg.count != 8'h00);
        end else if (running_reg && us_tick) begin
            us_reg <= us_next;
            idx_reg <= idx_next;
            running_reg <= !last_done;
        end
    end

    // led drive: slot keeps timing but light is suppressed
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= in_pulse && !cfg.light_off; // RULE_05
        end
    end

    assign led_pulse = pulse_reg;
    assign busy = running_reg;
endmodule : pulse_train_seq

// File: test_led_slot_timing_config.sv
// self-checking bench for the led slot timing register block
// assumes the zero-wait ahb-lite slave and a free microsecond tick
`timescale 1ns/100ps
module test_led_slot_timing_config;
    import led_slot_pkg::*;
    localparam int US = 125; // cycles per microsecond step
    logic ref_clk, rst_n, hsel, hwrite, hreadyout, hresp, sleep_mode;
    logic slot_a_start, slot_b_start, led_a_pulse, led_b_pulse, driver_a_on, driver_b_on;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, cathode_sel;
    logic [2:0] hsize;
    afe_ctrl_t afe_ctrl;
    slot_sel_t active_slot;
    int n_errors, num_checks, n, w, g, d;
    bit on, act_bad;
    led_slot_timing_config u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .slot_a_start(slot_a_start),
        .slot_b_start(slot_b_start), .sleep_mode(sleep_mode), .led_a_pulse(led_a_pulse),
        .led_b_pulse(led_b_pulse), .driver_a_on(driver_a_on), .driver_b_on(driver_b_on),
        .afe_ctrl(afe_ctrl), .cathode_sel(cathode_sel), .active_slot(active_slot));
    // clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_rdy();
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
    endtask : wait_rdy
    // one single-word transfer: address phase then data phase
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h000000, idx, 2'b00};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : bus
    task automatic wreg(input logic [7:0] idx, input logic [15:0] v);
        logic [31:0] r;
        bus(1'b1, idx, {16'h0000, v}, r);
    endtask : wreg
    task automatic rchk(input logic [7:0] idx, input logic [15:0] e);
        logic [31:0] r;
        bus(1'b0, idx, 32'h00000000, r);
        chk(r, {16'h0000, e});
    endtask : rchk
    // start one slot and time its pulses: count, first width, first start-to-start spacing, first delay
    task automatic run_train(input bit b);
        int t, last;
        logic p, q;
        n = 0;
        w = 0;
        g = 0;
        d = 0;
        on = 0;
        act_bad = 0;
        last = 0;
        q = 1'b0;
        if (b)
            slot_b_start <= 1'b1;
        else
            slot_a_start <= 1'b1;
        repeat (4) @(posedge ref_clk);
        slot_a_start <= 1'b0;
        slot_b_start <= 1'b0;
        for (t = 0; t < 60000; t++) begin
            @(posedge ref_clk);
            p = b ? led_b_pulse : led_a_pulse;
            if ((b ? driver_b_on : driver_a_on) && active_slot !== (b ? SLOT_B : SLOT_A))
                act_bad = 1;
            if (b ? driver_b_on : driver_a_on)
                on = 1;
            else if (on)
                break;
            if (p && !q) begin
                if (n == 1)
                    g = t - last;
                if (n == 0)
                    d = t;
                last = t;
                n++;
            end
            if (!p && q && n == 1)
                w = t - last;
            q = p;
        end
    endtask : run_train
    task automatic s_reset();
        rchk(IDX_SLOT_A_TRAIN, 16'h0818);
        rchk(IDX_SUPPRESS, 16'h0000);
        rchk(IDX_SLOT_B_SHAPE, 16'h0320);
        rchk(IDX_SLOT_B_TRAIN, 16'h0818);
        rchk(IDX_SHUTDOWN_EXT, 16'h0000);
        rchk(IDX_GLOBAL_CFG, 16'h3006);
        chk(cathode_sel, 32'h00000001);
        wreg(8'h32, 16'hFFFF);
        rchk(8'h32, 16'h0000);
    endtask : s_reset
    task automatic s_afe();
        wreg(IDX_GLOBAL_CFG, 16'h3286);
        wreg(IDX_SHUTDOWN_EXT, 16'h2400);
        rchk(IDX_GLOBAL_CFG, 16'h3286);
        chk({afe_ctrl.ch1_off, afe_ctrl.ch2_off, afe_ctrl.ch34_off}, 32'h0000001B);
        chk(cathode_sel, 32'h00000000);
    endtask : s_afe
    // override picks the slot code when awake and the sleep code when asleep
    task automatic s_override();
        rchk(IDX_BIAS_OVR, 16'h0020);
        wreg(IDX_BIAS_OVR, 16'h1EA0);
        @(posedge ref_clk);
        chk({afe_ctrl.override, cathode_sel}, 32'h00000006);
        sleep_mode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(cathode_sel, 32'h00000001);
        sleep_mode <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(cathode_sel, 32'h00000002);
        wreg(IDX_BIAS_OVR, 16'h0020);
    endtask : s_override
    // a disabled slot ignores its start request
    task automatic s_enable();
        wreg(IDX_SLOT_CTRL, 16'h0001);
        rchk(IDX_SLOT_CTRL, 16'h0001);
        slot_b_start <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk({driver_b_on, active_slot}, 32'h00000000);
        slot_b_start <= 1'b0;
        repeat (3) @(posedge ref_clk);
        wreg(IDX_SLOT_CTRL, 16'h0003);
    endtask : s_enable
    task automatic s_train_b();
        wreg(IDX_SLOT_B_SHAPE, 16'h0201);
        wreg(IDX_SLOT_B_TRAIN, 16'h0304);
        run_train(1'b1);
        chk(n, 32'h00000003);
        chk(w, 2 * US);
        chk(g, 4 * US);
        chk(d <= US + 8, 32'h00000001);
        chk(on, 32'h00000001);
        chk(act_bad, 32'h00000000);
    endtask : s_train_b
    task automatic s_train_a_msb();
        wreg(IDX_SHUTDOWN_EXT, 16'h0001);
        wreg(IDX_SLOT_A_TRAIN, 16'h0202);
        run_train(1'b0);
        chk(n, 32'h00000002);
        chk(g, 258 * US);
        chk(w, 3 * US);
        chk(act_bad, 32'h00000000);
    endtask : s_train_a_msb
    task automatic s_suppress();
        wreg(IDX_SUPPRESS, 16'h0300);
        wreg(IDX_SLOT_B_TRAIN, 16'h0204);
        run_train(1'b1);
        chk({on, n[7:0]}, 32'h00000100);
        wreg(IDX_SLOT_A_TRAIN, 16'h0104);
        run_train(1'b0);
        chk({on, n[7:0]}, 32'h00000100);
    endtask : s_suppress
    // watchdog
    initial begin
        repeat (90000) @(posedge ref_clk);
        n_errors++;
        print_verdict();
    end
    initial begin
        n_errors = 0;
        num_checks = 0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h00000000;
        slot_a_start = 1'b0;
        slot_b_start = 1'b0;
        sleep_mode = 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        s_reset();
        s_afe();
        s_override();
        s_enable();
        s_train_b();
        s_train_a_msb();
        s_suppress();
        print_verdict();
    end
endmodule : test_led_slot_timing_config
